// File: design/calc_limit_consts.svh
// constants of the calculate block limit monitor
`ifndef CALC_LIMIT_CONSTS_SVH
`define CALC_LIMIT_CONSTS_SVH
`define CB_NUM_BLOCKS     8
`define CB_ADDR_W         12
`define CB_DATA_W         32
`define CB_COUNT_W        16
// global registers
`define CB_OFS_MODE       12'h000
`define CB_OFS_CMD        12'h004
// per block window: base + index * stride
`define CB_BLK_BASE       12'h100
`define CB_BLK_STRIDE_SH  5
`define CB_BLK_TOP        12'h1ff
`define CB_OFS_CFG        3'h0
`define CB_OFS_LOW_POW    3'h1
`define CB_OFS_LOW_RAT    3'h2
`define CB_OFS_UPP_POW    3'h3
`define CB_OFS_UPP_RAT    3'h4
`define CB_OFS_LOW_DATA   3'h5
`define CB_OFS_UPP_DATA   3'h6
`define CB_OFS_STATUS     3'h7
// command register fields
`define CB_CMD_CLR_LSB    0
`define CB_CMD_EVT_LSB    8
`define CB_CMD_EVT_W      4
// reset values and the unmapped read value
`define CB_CFG_RST        15'h0001
`define CB_LIMIT_RST      32'sh0
`define CB_UNUSED_RD      32'h0
// limit ranges, values in thousandths of the unit
`define CB_W_MAX          32'sh3b9ac618
`define CB_DBM_MAX        32'sh00015f90
`define CB_DBM_MIN        (-32'sh0001d4c0)
`define CB_UVOLT_MAX      32'sh00030121
`define CB_UVOLT_MIN      (-32'sh000032d2)
`define CB_PCT_MAX        32'sh000f4236
`define CB_PCT_MIN        (-32'sh000186a0)
`define CB_DB_MAX         32'sh00030d40
`define CB_PLAIN_MAX      32'sh7fffffff
`endif

// File: design/calc_limit_pkg.sv
// types of the calculate block limit monitor
package calc_limit_pkg;
    typedef enum logic [1:0] {
        SRC_TRACE = 2'h0,
        SRC_AVERAGE = 2'h1,
        SRC_PEAK_TO_AVERAGE = 2'h2,
        SRC_PEAK = 2'h3
    } source_t;

    typedef enum logic [1:0] {
        AUTO_OFF = 2'h0,
        AUTO_ON = 2'h1,
        AUTO_ONCE = 2'h2
    } auto_clear_t;

    typedef enum logic [1:0] {
        POW_DBM = 2'h0,
        POW_WATT = 2'h1,
        POW_UVOLT = 2'h2
    } pow_unit_t;

    typedef enum logic [1:0] {
        RAT_DB = 2'h0,
        RAT_PERCENT_DIFF = 2'h1,
        RAT_PLAIN = 2'h2
    } rat_unit_t;

    typedef enum logic [2:0] {
        MODE_CONT_AVG = 3'h0,
        MODE_BURST = 3'h1,
        MODE_TIMESLOT = 3'h2,
        MODE_TIMEGATE = 3'h3,
        MODE_SCOPE = 3'h4
    } meas_mode_t;

    typedef struct packed {
        rat_unit_t   ratUnit;
        pow_unit_t   powUnit;
        logic        relativeOn;
        logic        mathIsRatio;
        auto_clear_t autoClear;
        logic        upperEnable;
        logic        lowerEnable;
        logic        acousticWarningEnable;
        logic [1:0]  gate;
        source_t     source;
    } block_cfg_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  block;
        source_t     kind;
        logic [1:0]  gate;
        logic signed [31:0] value;
    } meas_t;

    typedef struct packed {
        logic signed [31:0] lowPow;
        logic signed [31:0] lowRat;
        logic signed [31:0] uppPow;
        logic signed [31:0] uppRat;
    } limits_t;
endpackage : calc_limit_pkg

// File: design/calc_block_limit_monitor.sv
// limit monitor and data source selection for eight calculate blocks
`timescale 1ns/1ns
`include "calc_limit_consts.svh"

// What this block does
// [RQ1] scope mode: block takes trace, or gate average, peak-to-average or peak.
// [RQ2] other modes: only average values are processed, whatever source is chosen.
// [RQ3] per block acoustic warning enable; violation sounds warning; reset clears it.
// [RQ4] immediate clear resets fail state and violation counter of addressed block.
// [RQ5] automatic clear on continuous_start start, measure or read query.
// [RQ6] automatic clear once: only the next start event clears, then no more.
// [RQ7] fail status reports any limit violation; zero means none occurred.
// [RQ8] fail status cleared by reset and clear command, otherwise sticky.
// [RQ9] readable per block count of limit violations.
// [RQ10] violation counter zeroed by reset and clear command.
// [RQ11] programmable lower limit per block; values below it are detected.
// [RQ12] limit range follows the current output unit.
// [RQ13] power lower limit in dBm, W or dB microvolt, range -120..90 dBm, reset 0.
// [RQ14] ratio lower limit in dB, percent or plain, range -200..200 dB, reset 0.
// [RQ15] lower limit checked only while enabled; reset disables it.
// [RQ16] programmable upper limit per block; values above it are detected.
// [RQ17] power upper limit in dBm, W or dB microvolt, range -120..90 dBm, reset 0.
// [RQ18] ratio upper limit in dB, percent or plain, range -200..200 dB, reset 0.
// [RQ19] upper limit checked only while enabled; reset disables it.
// [RQ20] output unit depends on math function and relative state.
// [RQ21] each violating value sets fail status and counts once.
module calc_block_limit_monitor #(
    parameter int NUM_BLOCKS = `CB_NUM_BLOCKS,
    parameter int COUNT_W    = `CB_COUNT_W
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic [`CB_ADDR_W-1:0]     regAddr,
    input  wire logic [`CB_DATA_W-1:0]     regWdata,
    input  wire logic                      regWr,
    input  wire logic                      regRd,
    output logic      [`CB_DATA_W-1:0]     regRdata,
    input  wire calc_limit_pkg::meas_t     meas,
    output logic      [NUM_BLOCKS-1:0]     warnBeep,
    output logic      [NUM_BLOCKS-1:0]     failFlag
);
    import calc_limit_pkg::*;

    // counter stops at all ones, never wraps
    localparam logic [COUNT_W-1:0] COUNT_MAX = {COUNT_W{1'b1}};

    meas_mode_t                  mode;
    meas_mode_t                  next_mode;
    block_cfg_t                  cfg         [NUM_BLOCKS];
    block_cfg_t                  next_cfg    [NUM_BLOCKS];
    limits_t                     lim         [NUM_BLOCKS];
    limits_t                     next_lim    [NUM_BLOCKS];
    logic [NUM_BLOCKS-1:0]       fail;
    logic [NUM_BLOCKS-1:0]       next_fail;
    logic [COUNT_W-1:0]          count       [NUM_BLOCKS];
    logic [COUNT_W-1:0]          next_count  [NUM_BLOCKS];
    logic [NUM_BLOCKS-1:0]       next_warnBeep;
    logic [`CB_DATA_W-1:0]       next_regRdata;

    // whether an address falls into the block window
    function automatic logic inBlockWindow(input logic [`CB_ADDR_W-1:0] a);
        inBlockWindow = (a >= `CB_BLK_BASE) && (a <= `CB_BLK_TOP) && (a[1:0] == 2'h0);
    endfunction : inBlockWindow

    // block index of an address
    function automatic logic [2:0] blockOf(input logic [`CB_ADDR_W-1:0] a);
        logic [`CB_ADDR_W-1:0] rel;
        rel = a - `CB_BLK_BASE;
        blockOf = rel[`CB_BLK_STRIDE_SH +: 3];
    endfunction : blockOf

    // register slot inside a block
    function automatic logic [2:0] regOf(input logic [`CB_ADDR_W-1:0] a);
        regOf = a[4:2];
    endfunction : regOf

    // ratio units once the math function or relative mode says so
    function automatic logic unitIsRatio(input block_cfg_t c);
        unitIsRatio = c.mathIsRatio || c.relativeOn;
    endfunction : unitIsRatio

    // range of the current unit, power or ratio family
    function automatic logic signed [31:0] rangeMax(input logic isRatio, input block_cfg_t c);
        if (isRatio) begin
            unique case (c.ratUnit)
                RAT_DB:           rangeMax = `CB_DB_MAX;
                RAT_PERCENT_DIFF: rangeMax = `CB_PCT_MAX;
                default:          rangeMax = `CB_PLAIN_MAX;
            endcase
        end else begin
            unique case (c.powUnit)
                POW_WATT: rangeMax = `CB_W_MAX;
                POW_UVOLT: rangeMax = `CB_UVOLT_MAX;
                default:  rangeMax = `CB_DBM_MAX;
            endcase
        end
    endfunction : rangeMax

    // lower end of the same range
    function automatic logic signed [31:0] rangeMin(input logic isRatio, input block_cfg_t c);
        if (isRatio) begin
            unique case (c.ratUnit)
                RAT_DB:           rangeMin = -`CB_DB_MAX;
                RAT_PERCENT_DIFF: rangeMin = `CB_PCT_MIN;
                default:          rangeMin = -`CB_PLAIN_MAX;
            endcase
        end else begin
            unique case (c.powUnit)
                POW_WATT: rangeMin = -`CB_W_MAX;
                POW_UVOLT: rangeMin = `CB_UVOLT_MIN;
                default:  rangeMin = `CB_DBM_MIN;
            endcase
        end
    endfunction : rangeMin

    // out-of-range limits saturate rather than being refused
    function automatic logic signed [31:0] clampLimit(input logic isRatio, input block_cfg_t c,
                                                      input logic signed [31:0] v);
        logic signed [31:0] hi;
        logic signed [31:0] lo;
        hi = rangeMax(isRatio, c);
        lo = rangeMin(isRatio, c);

        if (v > hi) begin
            clampLimit = hi;
        end else if (v < lo) begin
            clampLimit = lo;
        end else begin
            clampLimit = v;
        end
    endfunction : clampLimit

    // does a measured value feed this block
    function automatic logic sourceMatch(input meas_mode_t m, input block_cfg_t c, input meas_t d);
        if (m == MODE_SCOPE) begin
            if (c.source == SRC_TRACE) begin
                sourceMatch = (d.kind == SRC_TRACE);
            end else begin
                sourceMatch = (d.kind == c.source) && (d.gate == c.gate);
            end
        end else begin
            sourceMatch = (d.kind == SRC_AVERAGE);
        end
    endfunction : sourceMatch

    // command decode shared by all blocks
    logic                        cmdWrite;
    logic                        startEvent;
    logic [NUM_BLOCKS-1:0]       clearCmd;

    always_comb begin
        cmdWrite   = regWr && (regAddr == `CB_OFS_CMD);
        startEvent = cmdWrite && (regWdata[`CB_CMD_EVT_LSB +: `CB_CMD_EVT_W] != '0);
        clearCmd   = cmdWrite ? regWdata[`CB_CMD_CLR_LSB +: NUM_BLOCKS] : '0;
    end

    // block state: config, limits, fail flag, counter
    always_comb begin
        logic               accept;
        logic               ratio;
        logic               wrHere;
        logic               violLow;
        logic               violUpp;
        logic               viol;
        logic               clr;
        logic signed [31:0] lowLim;
        logic signed [31:0] uppLim;
        accept = 1'b0;
        ratio = 1'b0;
        wrHere = 1'b0;
        violLow = 1'b0;
        violUpp = 1'b0;
        viol = 1'b0;
        clr = 1'b0;
        lowLim = '0;
        uppLim = '0;

        next_mode = mode;
        if (regWr && regAddr == `CB_OFS_MODE) begin
            next_mode = meas_mode_t'(regWdata[2:0]);
        end

        for (int b = 0; b < NUM_BLOCKS; b++) begin
            // hold unless written
            next_cfg[b] = cfg[b];
            next_lim[b] = lim[b];
            wrHere = regWr && inBlockWindow(regAddr) && (blockOf(regAddr) == 3'(b));
            // [RQ20] unit family from math and relative
            ratio = unitIsRatio(cfg[b]);

            if (wrHere) begin
                unique case (regOf(regAddr))
                    `CB_OFS_CFG: begin
                        next_cfg[b] = block_cfg_t'(regWdata[14:0]);
                    end
                    // [RQ13] power lower limit, clamped
                    `CB_OFS_LOW_POW: begin
                        next_lim[b].lowPow = clampLimit(1'b0, cfg[b], regWdata);
                    end
                    // [RQ14] ratio lower limit, clamped
                    `CB_OFS_LOW_RAT: begin
                        next_lim[b].lowRat = clampLimit(1'b1, cfg[b], regWdata);
                    end
                    // [RQ17] power upper limit, clamped
                    `CB_OFS_UPP_POW: begin
                        next_lim[b].uppPow = clampLimit(1'b0, cfg[b], regWdata);
                    end
                    // [RQ18] ratio upper limit, clamped
                    `CB_OFS_UPP_RAT: begin
                        next_lim[b].uppRat = clampLimit(1'b1, cfg[b], regWdata);
                    end
                    // [RQ12] range of current unit
                    `CB_OFS_LOW_DATA: begin
                        if (ratio) begin
                            next_lim[b].lowRat = clampLimit(1'b1, cfg[b], regWdata);
                        end else begin
                            next_lim[b].lowPow = clampLimit(1'b0, cfg[b], regWdata);
                        end
                    end
                    `CB_OFS_UPP_DATA: begin
                        if (ratio) begin
                            next_lim[b].uppRat = clampLimit(1'b1, cfg[b], regWdata);
                        end else begin
                            next_lim[b].uppPow = clampLimit(1'b0, cfg[b], regWdata);
                        end
                    end
                    default: begin
                    end
                endcase
            end

            // [RQ1] scope source selection
            // [RQ2] average only outside scope
            accept = meas.valid && (meas.block == 3'(b)) && sourceMatch(mode, cfg[b], meas);

            // limits of the current unit family
            lowLim = ratio ? lim[b].lowRat : lim[b].lowPow;
            uppLim = ratio ? lim[b].uppRat : lim[b].uppPow;
            // [RQ11] [RQ15] below lower limit, when enabled
            violLow = cfg[b].lowerEnable && (meas.value < lowLim);
            // [RQ16] [RQ19] above upper limit, when enabled
            violUpp = cfg[b].upperEnable && (meas.value > uppLim);
            // refused values never count
            viol = accept && (violLow || violUpp);

            // [RQ4] immediate clear
            // [RQ5] start event clear
            clr = clearCmd[b] || (startEvent && cfg[b].autoClear != AUTO_OFF);

            // [RQ6] once disarms after first event
            if (startEvent && cfg[b].autoClear == AUTO_ONCE && !(wrHere && regOf(regAddr) == `CB_OFS_CFG)) begin
                next_cfg[b].autoClear = AUTO_OFF;
            end

            // [RQ21] a violation outweighs a same-cycle clear
            // [RQ7] [RQ8] sticky fail flag
            if (viol) begin
                next_fail[b] = 1'b1;
            end else if (clr) begin
                next_fail[b] = 1'b0;
            end else begin
                next_fail[b] = fail[b];
            end

            // [RQ9] [RQ10] counter, saturating
            if (viol) begin
                if (clr) begin
                    next_count[b] = COUNT_W'(1);
                end else if (count[b] != COUNT_MAX) begin
                    next_count[b] = count[b] + COUNT_W'(1);
                end else begin
                    next_count[b] = count[b];
                end
            end else if (clr) begin
                next_count[b] = '0;
            end else begin
                next_count[b] = count[b];
            end

            // beep is a pulse; the flag keeps the history
            // [RQ3] warning pulse when enabled
            next_warnBeep[b] = viol && cfg[b].acousticWarningEnable;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode <= MODE_CONT_AVG;
            fail <= '0;
            warnBeep <= '0;

            for (int b = 0; b < NUM_BLOCKS; b++) begin
                // [RQ3] [RQ15] [RQ19] reset clears enables
                cfg[b] <= block_cfg_t'(`CB_CFG_RST);
                // [RQ13] [RQ14] [RQ17] [RQ18] limits reset to zero
                lim[b] <= '{`CB_LIMIT_RST, `CB_LIMIT_RST, `CB_LIMIT_RST, `CB_LIMIT_RST};
                // [RQ10] counter zeroed
                count[b] <= '0;
            end
        end else begin
            mode <= next_mode;
            fail <= next_fail;
            warnBeep <= next_warnBeep;

            for (int b = 0; b < NUM_BLOCKS; b++) begin
                cfg[b] <= next_cfg[b];
                lim[b] <= next_lim[b];
                count[b] <= next_count[b];
            end
        end
    end

    // flag leaves straight from its register
    assign failFlag = fail;

    // read path, data in the cycle after the strobe
    always_comb begin
        logic [2:0] blk;
        blk = blockOf(regAddr);
        // unmapped or idle reads return zero
        next_regRdata = `CB_UNUSED_RD;
        if (regRd) begin
            if (regAddr == `CB_OFS_MODE) begin
                next_regRdata = {29'h0, mode};
            end else if (inBlockWindow(regAddr) && 32'(blk) < NUM_BLOCKS) begin
                unique case (regOf(regAddr))
                    `CB_OFS_CFG:      next_regRdata = {17'h0, cfg[blk]};
                    `CB_OFS_LOW_POW:  next_regRdata = lim[blk].lowPow;
                    `CB_OFS_LOW_RAT:  next_regRdata = lim[blk].lowRat;
                    `CB_OFS_UPP_POW:  next_regRdata = lim[blk].uppPow;
                    `CB_OFS_UPP_RAT:  next_regRdata = lim[blk].uppRat;
                    `CB_OFS_LOW_DATA: next_regRdata = unitIsRatio(cfg[blk]) ? lim[blk].lowRat : lim[blk].lowPow;
                    `CB_OFS_UPP_DATA: next_regRdata = unitIsRatio(cfg[blk]) ? lim[blk].uppRat : lim[blk].uppPow;
                    // [RQ7] [RQ9] fail in bit 31, count low
                    default:          next_regRdata = {fail[blk], 15'h0, count[blk]};
                endcase
            end
        end
    end

    // answer stands one cycle, then falls to zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdata <= '0;
        end else begin
            regRdata <= next_regRdata;
        end
    end
endmodule : calc_block_limit_monitor

// File: tb/calc_limit_rules_monitor.sv
// port assertions of the calculate block limit monitor
`timescale 1ns/1ns
`include "calc_limit_consts.svh"
module calc_limit_rules_monitor #(
    parameter int NUM_BLOCKS = `CB_NUM_BLOCKS,
    parameter int COUNT_W    = `CB_COUNT_W
) (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic [`CB_ADDR_W-1:0] regAddr,
    input wire logic [`CB_DATA_W-1:0] regWdata,
    input wire logic                  regWr,
    input wire logic                  regRd,
    input wire logic [`CB_DATA_W-1:0] regRdata,
    input wire calc_limit_pkg::meas_t meas,
    input wire logic [NUM_BLOCKS-1:0] warnBeep,
    input wire logic [NUM_BLOCKS-1:0] failFlag
);
    import calc_limit_pkg::*;
    localparam logic [NUM_BLOCKS-1:0] ONE = 1;
    logic                  cmdWr;
    logic                  measValid;
    logic [2:0]            measBlock;
    logic [NUM_BLOCKS-1:0] clrBits;
    // any command write may clear, immediate or automatic
    assign cmdWr     = regWr && regAddr == `CB_OFS_CMD;
    assign measValid = meas.valid;
    assign measBlock = meas.block;
    assign clrBits   = cmdWr ? regWdata[NUM_BLOCKS-1:0] : '0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_read_data_idle: assert property (
        !$past(regRd) |-> regRdata == '0) else $error("read data not zero outside read answer");
    a_fail_sticky_set: assert property (
        ($past(failFlag) & ~failFlag) != '0 |-> $past(cmdWr)) else $error("fail flag dropped without command");
    a_fail_rise_cause: assert property (
        (failFlag & ~$past(failFlag)) != '0 |-> $past(measValid) && (failFlag & ~$past(failFlag)) == (ONE << $past(measBlock)))
        else $error("fail flag rose without value of that block");
    a_beep_from_value: assert property (
        warnBeep != '0 |-> $past(measValid) && warnBeep == (ONE << $past(measBlock)))
        else $error("warning pulse without value of that block");
    a_beep_with_fail: assert property (
        warnBeep != '0 |-> (failFlag & warnBeep) == warnBeep) else $error("warning pulse without fail flag");
    a_fail_held_quiet: assert property (
        !$past(measValid) && !$past(regWr) |-> $stable(failFlag)) else $error("fail flag moved while idle");
    a_reset_clears_out: assert property (
        $fell(rst) |-> failFlag == '0 && warnBeep == '0 && regRdata == '0) else $error("outputs not clear after reset");
    a_clear_cmd_works: assert property (
        $past(clrBits) != '0 && !$past(measValid) |-> (failFlag & $past(clrBits)) == '0)
        else $error("clear command left fail flag set");
endmodule : calc_limit_rules_monitor

bind calc_block_limit_monitor calc_limit_rules_monitor #(.NUM_BLOCKS(NUM_BLOCKS), .COUNT_W(COUNT_W))
    calc_limit_rules_monitor_i (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .meas(meas), .warnBeep(warnBeep), .failFlag(failFlag));

// File: tb/calc_block_limit_monitor_tb_top.sv
// self-checking bench of the calculate block limit monitor
`timescale 1ns/1ns
`include "calc_limit_consts.svh"
module calc_block_limit_monitor_tb_top;
    import calc_limit_pkg::*;
    typedef struct packed {
        logic [31:0] data;
        logic [7:0]  flags;
    } note_t;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] regAddr = '0;
    logic [31:0] regWdata = '0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [31:0] regRdata;
    meas_t       meas = '0;
    logic [7:0]  warnBeep;
    logic [7:0]  failFlag;
    note_t       rdQ[$];
    logic [7:0]  beepQ[$];
    logic [7:0]  expFail = '0;
    logic [7:0]  beepOn = '0;
    int          expCnt[8];
    logic [31:0] seed = 32'h0b9674f5;
    logic        rdPend = 1'b0;
    int          fails = 0;
    int          num_checks = 0;
    // clamp table: config, word offset, written, read back
    logic [31:0] tCfg[10] = '{0, 0, 0, 0, 32'h1000, 32'h1000, 32'h2000, 32'h2000, 32'h800, 32'h4000};
    int          tOfs[10] = '{1, 3, 2, 4, 3, 1, 2, 4, 3, 2};
    logic [31:0] tWr[10] = '{-200000, 100000, -300000, 300000, 300000, -20000, -200000, 2000000, 32'h7fffffff,
                             32'h80000000};
    logic [31:0] tExp[10] = '{`CB_DBM_MIN, `CB_DBM_MAX, -`CB_DB_MAX, `CB_DB_MAX, `CB_UVOLT_MAX, `CB_UVOLT_MIN,
                              `CB_PCT_MIN, `CB_PCT_MAX, `CB_W_MAX, -`CB_PLAIN_MAX};

    calc_block_limit_monitor calc_block_limit_monitor_i (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .meas(meas),
        .warnBeep(warnBeep), .failFlag(failFlag));

    always #5 clk = ~clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [11:0] ba(input int b, input int o);
        return `CB_BLK_BASE + 12'(b << `CB_BLK_STRIDE_SH) + 12'(o << 2);
    endfunction : ba

    task automatic cmpWord(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmpWord

    task automatic cmpFlags(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmpFlags

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        rdQ.push_back('{d, expFail});
        @(posedge clk);
        regRd <= 1'b0;
    endtask : rd

    task automatic setCfg(input int b, input logic [31:0] c);
        beepOn[b] = c[4];
        wr(ba(b, `CB_OFS_CFG), c);
    endtask : setCfg

    task automatic stat(input int b);
        rd(ba(b, `CB_OFS_STATUS), {expFail[b], 15'h0, 16'(expCnt[b])});
    endtask : stat

    task automatic send(input int b, input source_t k, input logic [1:0] g, input logic [31:0] v, input logic viol);
        @(posedge clk);
        meas <= '{1'b1, 3'(b), k, g, v};
        if (viol) begin
            expFail[b] = 1'b1;
            expCnt[b]++;
            if (beepOn[b]) beepQ.push_back(8'h1 << b);
        end
        @(posedge clk);
        meas.valid <= 1'b0;
    endtask : send

    task automatic forget(input int b);
        expFail[b] = 1'b0;
        expCnt[b] = 0;
    endtask : forget

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    // read answers stand one cycle only, so compare on that edge
    always @(posedge clk) begin
        if (rdPend && rdQ.size() > 0) begin
            cmpWord("read data", rdQ[0].data, regRdata);
            cmpFlags("fail flags", rdQ[0].flags, failFlag);
            void'(rdQ.pop_front());
        end
        if (warnBeep !== 8'h0) begin
            cmpFlags("warning", (beepQ.size() > 0) ? beepQ.pop_front() : 8'h0, warnBeep);
        end
        rdPend <= regRd;
    end

    initial begin
        #200000;
        fails++;
        results();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int b = 0; b < 8; b++) begin
            rd(ba(b, `CB_OFS_CFG), 32'(`CB_CFG_RST));
            for (int o = 1; o < 8; o++) rd(ba(b, o), 32'h0);
        end
        rd(`CB_OFS_MODE, 32'h0);
        wr(12'h080, 32'hffffffff);
        rd(12'h080, `CB_UNUSED_RD);
        $display("test reset values done");
        for (int i = 0; i < 10; i++) begin
            setCfg(5, tCfg[i]);
            wr(ba(5, tOfs[i]), tWr[i]);
            rd(ba(5, tOfs[i]), tExp[i]);
        end
        wr(ba(4, `CB_OFS_LOW_POW), 32'd5000);
        wr(ba(4, `CB_OFS_LOW_RAT), 32'd7000);
        rd(ba(4, `CB_OFS_LOW_DATA), 32'd5000);
        setCfg(4, 32'h400);
        rd(ba(4, `CB_OFS_LOW_DATA), 32'd7000);
        wr(ba(4, `CB_OFS_UPP_DATA), 32'd3000);
        rd(ba(4, `CB_OFS_UPP_RAT), 32'd3000);
        wr(ba(4, `CB_OFS_LOW_DATA), -32'd300000);
        rd(ba(4, `CB_OFS_LOW_RAT), -`CB_DB_MAX);
        $display("test limit ranges done");
        wr(ba(1, `CB_OFS_UPP_POW), 32'd10000);
        wr(ba(1, `CB_OFS_LOW_POW), -32'd10000);
        setCfg(1, 32'h53);
        send(1, SRC_AVERAGE, 2'h0, -32'd50000, 1'b0);
        setCfg(1, 32'h73);
        for (int m = 0; m < 4; m++) begin
            wr(`CB_OFS_MODE, 32'(m));
            send(1, SRC_PEAK, 2'h0, 32'd50000, 1'b0);
            send(1, SRC_AVERAGE, 2'h0, 32'd10000, 1'b0);
            send(1, SRC_AVERAGE, 2'h1, 32'd10001, 1'b1);
            send(1, SRC_AVERAGE, 2'h0, -32'd10001, 1'b1);
            seed = lfsr(seed);
            send(1, SRC_AVERAGE, 2'h0, 32'(int'(seed % 32'd20001) - 10000), 1'b0);
        end
        stat(1);
        setCfg(1, 32'h30);
        send(1, SRC_AVERAGE, 2'h0, 32'd50000, 1'b0);
        stat(1);
        $display("test limit compare done");
        setCfg(0, 32'h40);
        send(0, SRC_AVERAGE, 2'h0, 32'd1, 1'b1);
        wr(`CB_OFS_CMD, 32'h2);
        forget(1);
        stat(1);
        stat(0);
        wr(`CB_OFS_CMD, 32'h1);
        forget(0);
        stat(0);
        $display("test clear done");
        wr(`CB_OFS_MODE, 32'h4);
        for (int k = 0; k < 4; k++) begin
            setCfg(2, 32'h40 | 32'(k << 2) | 32'(k));
            send(2, source_t'(k), 2'(k), 32'd5, 1'b1);
            send(2, source_t'(k), 2'(k ^ 1), 32'd5, k == 0);
            send(2, source_t'(k ^ 1), 2'(k), 32'd5, 1'b0);
        end
        stat(2);
        $display("test scope sources done");
        setCfg(3, 32'hc1);
        for (int e = 0; e < 4; e++) begin
            send(3, SRC_AVERAGE, 2'h0, 32'd5, 1'b1);
            wr(`CB_OFS_CMD, 32'h1 << (8 + e));
            forget(3);
            stat(3);
        end
        setCfg(3, 32'h141);
        send(3, SRC_AVERAGE, 2'h0, 32'd5, 1'b1);
        wr(`CB_OFS_CMD, 32'h100);
        forget(3);
        rd(ba(3, `CB_OFS_CFG), 32'h41);
        send(3, SRC_AVERAGE, 2'h0, 32'd5, 1'b1);
        wr(`CB_OFS_CMD, 32'h200);
        stat(3);
        $display("test auto clear done");
        repeat (4) @(posedge clk);
        if (rdQ.size() != 0 || beepQ.size() != 0) begin
            fails++;
            $display("[ERR] pending notes expected 0 seen %0d", rdQ.size() + beepQ.size());
        end
        results();
    end
endmodule : calc_block_limit_monitor_tb_top
